// ---- verilog/acd_action_decoder.sv ----
// Purpose: decode and merge the two access-control lookup action words
// Assumes: both lookups always return a word (hit or default) with result_valid
// Notes:   decode path is combinational; the register port, the counters and the command capture are clocked
//
// The register addresses and the plain strobed port are this design's own decisions.
`include "acd_defs.svh"

module acd_action_decoder
    import acd_pkg::*;
#(
    parameter int CPU_PORT = 10,   // bit of the port set that is the CPU port
    parameter int IGR_PORTS = 12   // number of ingress port numbers
)
(
    input  wire logic                      clk,
    input  wire logic                      rst,
    // lookup results
    input  wire logic                      result_valid,
    input  wire logic [`ACD_ACT_W-1:0]     action_first,
    input  wire logic [`ACD_ACT_W-1:0]     action_second,
    input  wire logic [3:0]                ingress_port,
    input  wire logic [`ACD_PSET_W-1:0]    fwd_filter_set,
    input  wire logic [`ACD_PSET_W-1:0]    addr_lookup_set,
    // to the forwarding stage
    output logic                           out_valid,
    output logic                           learn_suppress,
    output logic                           police_on,
    output logic [`ACD_POL_SEL_W-1:0]      policer_select,
    output logic                           policer_exclusive,
    output logic [1:0]                     port_set_mode,
    output logic [`ACD_PSET_W-1:0]         egress_port_set,
    output logic [`ACD_PSET_W-1:0]         fwd_dest_set,
    // to the egress rewriter
    output logic [`ACD_REW_W-1:0]          rewrite_command,
    output logic                           rew_none,
    output logic                           rew_mac_swap,
    output logic                           rew_ptp_one_step,
    output logic                           rew_corr_addsub,
    output logic                           rew_add_egress_dly,
    output logic                           rew_sub_rx_dly,
    output logic [1:0]                     rew_dly_sel,
    output logic                           rew_ptp_two_step,
    output logic [`ACD_REW_ID_W-1:0]       rew_ts_id,
    output logic                           rew_ptp_origin,
    // register port
    input  wire logic [`ACD_ADDR_W-1:0]    reg_addr,
    input  wire logic [31:0]               reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic [31:0]                    reg_rdata
);

    // classify a rewrite command; used for the live and the logged command
    function automatic acd_rew_kind_t rew_kind(input logic [`ACD_REW_W-1:0] cmd);
        acd_rew_kind_t k;
        k = ACD_RK_OTHER;
        if (cmd[3:0] == `ACD_REW_NOP)
            k = ACD_RK_NOP;
        else if (cmd[3:0] == `ACD_REW_SWAP)
            k = ACD_RK_SWAP;
        else if (cmd[3:0] == `ACD_REW_ORIGIN)
            k = ACD_RK_ORIGIN;
        else if (cmd[2:0] == `ACD_REW_ONE_STEP)
            k = ACD_RK_ONE;
        else if (cmd[2:0] == `ACD_REW_TWO_STEP)
            k = ACD_RK_TWO;
        return k;
    endfunction : rew_kind

    // fields of the first lookup
    acd_mode_t                   f_mode;
    logic                        f_lrn;
    logic                        f_pol_on;
    logic [`ACD_POL_SEL_W-1:0]   f_pol_sel;
    // exclusive bit of the first lookup is left open: honoured from the second only
    logic [`ACD_PSET_W-1:0]      f_pset;
    logic [`ACD_REW_W-1:0]       f_rew;
    // fields of the second lookup
    acd_mode_t                   s_mode;
    logic                        s_lrn;
    // police-on of the second lookup is left open: honoured from the first only
    // policer index of the second lookup is left open with it
    logic                        s_excl;
    logic [`ACD_PSET_W-1:0]      s_pset;
    logic [`ACD_REW_W-1:0]       s_rew;

    // software state
    logic                        enable_q;      // actions applied when set
    logic [IGR_PORTS-1:0]        backplane_q;   // ingress ports in backplane mode
    logic [`ACD_REW_W-1:0]       last_rew_q;    // last merged rewrite command
    logic [`ACD_CNT_W-1:0]       frame_cnt_q;   // decoded results
    logic [`ACD_CNT_W-1:0]       lrn_cnt_q;     // results with learning suppressed
    logic [31:0]                 rdata_q;       // read data, one cycle after strobe

    // merged and decoded values
    acd_mode_t                   m_mode;
    logic [`ACD_PSET_W-1:0]      m_pset;
    logic [`ACD_REW_W-1:0]       m_rew;
    acd_rew_kind_t               m_kind;
    logic                        on_backplane;
    logic [`ACD_PSET_W-1:0]      normal_set;
    logic [`ACD_PSET_W-1:0]      acted_set;
    logic [`ACD_PSET_W-1:0]      cpu_bit;

    acd_field_slice u_first
    (
        .action_word                  (action_first),
        .port_set_mode                (f_mode),
        .learn_suppress               (f_lrn),
        .acl_police_on                (f_pol_on),
        .acl_policer_select           (f_pol_sel),
        .classifier_policer_exclusive (),
        .egress_port_set              (f_pset),
        .rewrite_command              (f_rew)
    );

    acd_field_slice u_second
    (
        .action_word                  (action_second),
        .port_set_mode                (s_mode),
        .learn_suppress               (s_lrn),
        .acl_police_on                (),
        .acl_policer_select           (),
        .classifier_policer_exclusive (s_excl),
        .egress_port_set              (s_pset),
        .rewrite_command              (s_rew)
    );

    // merge the port-set treatment of the two lookups
    always_comb
    begin
        // stronger mode wins: none < permit < policy < redirect
        m_mode = (s_mode > f_mode) ? s_mode : f_mode;
        if (s_mode == ACD_MODE_REDIRECT || f_mode == ACD_MODE_NONE)
            m_pset = s_pset;
        else if (s_mode == ACD_MODE_NONE)
            m_pset = f_pset;
        else
            m_pset = f_pset & s_pset;
        // disabled block passes forwarding through unchanged
        if (!enable_q)
            m_mode = ACD_MODE_NONE;
    end

    assign m_rew = (s_rew[3:0] == `ACD_REW_NOP) ? f_rew : s_rew;

    assign out_valid = result_valid;

    assign learn_suppress = enable_q & (f_lrn | s_lrn);

    assign police_on = enable_q & f_pol_on;

    assign policer_select = f_pol_sel;

    assign policer_exclusive = enable_q & s_excl;

    assign port_set_mode = m_mode;
    assign egress_port_set = m_pset;

    // forwarding set with the merged port set applied
    always_comb
    begin
        normal_set = fwd_filter_set & addr_lookup_set;
        case (m_mode)
            ACD_MODE_PERMIT:   acted_set = normal_set & m_pset;
            ACD_MODE_POLICY:   acted_set = fwd_filter_set & m_pset;
            ACD_MODE_REDIRECT: acted_set = m_pset;
            default:           acted_set = normal_set;
        endcase
    end

    assign cpu_bit = `ACD_PSET_W'(1) << CPU_PORT;
    assign fwd_dest_set = (acted_set & ~cpu_bit) | (normal_set & cpu_bit);

    assign rewrite_command = enable_q ? m_rew : `ACD_REW_W'(0);
    assign m_kind = enable_q ? rew_kind(m_rew) : ACD_RK_NOP;

    assign rew_none = (m_kind == ACD_RK_NOP);

    assign rew_mac_swap = (m_kind == ACD_RK_SWAP);

    assign rew_ptp_one_step = (m_kind == ACD_RK_ONE);

    assign rew_corr_addsub = rew_ptp_one_step & m_rew[`ACD_REW_ADDSUB];

    assign rew_add_egress_dly = rew_ptp_one_step & m_rew[`ACD_REW_DLY_BIT];

    // backplane ingress ports keep their rx stamp as received
    assign on_backplane = (int'(ingress_port) < IGR_PORTS) ? backplane_q[ingress_port] : 1'b0;

    assign rew_sub_rx_dly = rew_ptp_one_step & m_rew[`ACD_REW_DLY_BIT] & ~on_backplane;

    assign rew_dly_sel = rew_ptp_one_step ? m_rew[`ACD_REW_DSEL_LSB +: 2] : ACD_DLY_NONE;

    assign rew_ptp_two_step = (m_kind == ACD_RK_TWO);
    assign rew_ts_id = rew_ptp_two_step ? m_rew[`ACD_REW_ID_LSB +: `ACD_REW_ID_W] : `ACD_REW_ID_W'(0);

    assign rew_ptp_origin = (m_kind == ACD_RK_ORIGIN);

    // control register; clearing enable turns every action into a no-op
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            enable_q <= `ACD_CTRL_RESET;
        else if (reg_wr && reg_addr == `ACD_REG_CTRL)
            enable_q <= reg_wdata[0];
    end

    // backplane port mask register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            backplane_q <= IGR_PORTS'(`ACD_BKPL_RESET);
        else if (reg_wr && reg_addr == `ACD_REG_BACKPLANE)
            backplane_q <= reg_wdata[IGR_PORTS-1:0];
    end

    // capture of the last merged command for software
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            last_rew_q <= `ACD_REW_W'(0);
        else if (result_valid)
            last_rew_q <= rewrite_command;
    end

    // counters; a write to the count register clears both, a result in
    // the same cycle still counts so no event is lost
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            frame_cnt_q <= `ACD_CNT_W'(0);
            lrn_cnt_q   <= `ACD_CNT_W'(0);
        end
        else if (reg_wr && reg_addr == `ACD_REG_COUNTS)
        begin
            frame_cnt_q <= `ACD_CNT_W'(result_valid);
            lrn_cnt_q   <= `ACD_CNT_W'(result_valid & learn_suppress);
        end
        else if (result_valid)
        begin
            frame_cnt_q <= frame_cnt_q + `ACD_CNT_W'(1);
            if (learn_suppress)
                lrn_cnt_q <= lrn_cnt_q + `ACD_CNT_W'(1);
        end
    end

    // read data, valid only in the cycle after the strobe
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata_q <= 32'h0;
        else if (!reg_rd)
            rdata_q <= 32'h0;
        else if (reg_addr == `ACD_REG_CTRL)
            rdata_q <= 32'(enable_q);
        else if (reg_addr == `ACD_REG_BACKPLANE)
            rdata_q <= 32'(backplane_q);
        else if (reg_addr == `ACD_REG_LAST_REW)
            rdata_q <= {7'h0, rew_kind(last_rew_q), 10'h0, last_rew_q};
        else if (reg_addr == `ACD_REG_COUNTS)
            rdata_q <= {lrn_cnt_q, frame_cnt_q};
        else
            rdata_q <= 32'h0;  // unmapped reads as zero
    end

    assign reg_rdata = rdata_q;

endmodule : acd_action_decoder

// ---- pkg/acd_defs.svh ----
// Purpose: field positions, codes and register offsets of the action decoder
// Assumes: included by bare name from the package and the design modules
// Notes:   definitions only
`ifndef ACD_DEFS_SVH
`define ACD_DEFS_SVH

// action word layout
`define ACD_ACT_W         40
`define ACD_MODE_LSB      5
`define ACD_MODE_W        2
`define ACD_LRN_BIT       8
`define ACD_POL_ON_BIT    9
`define ACD_POL_SEL_LSB   10
`define ACD_POL_SEL_W     9
`define ACD_EXCL_BIT      19
`define ACD_PSET_LSB      20
`define ACD_PSET_W        11
`define ACD_REW_LSB       31
`define ACD_REW_W         9

// rewrite command codes
`define ACD_REW_NOP       4'h0
`define ACD_REW_SWAP      4'h8
`define ACD_REW_ORIGIN    4'h9
`define ACD_REW_ONE_STEP  3'h2
`define ACD_REW_TWO_STEP  3'h3
`define ACD_REW_ADDSUB    7
`define ACD_REW_DLY_BIT   5
`define ACD_REW_DSEL_LSB  3
`define ACD_REW_ID_LSB    3
`define ACD_REW_ID_W      6

// register map, byte addresses
`define ACD_ADDR_W        8
`define ACD_REG_CTRL      8'h00
`define ACD_REG_BACKPLANE 8'h04
`define ACD_REG_LAST_REW  8'h08
`define ACD_REG_COUNTS    8'h0C
`define ACD_CTRL_RESET    1'h1
`define ACD_BKPL_RESET    12'h000
`define ACD_CNT_W         16

`endif

// ---- pkg/acd_pkg.sv ----
// Purpose: types shared by the action decoder modules
// Assumes: acd_defs.svh gives the field widths
// Notes:   one-hot codes are written out for the rewrite kind
`include "acd_defs.svh"

package acd_pkg;

    // egress port-set treatment
    typedef enum logic [1:0]
    {
        ACD_MODE_NONE     = 2'h0,
        ACD_MODE_PERMIT   = 2'h1,
        ACD_MODE_POLICY   = 2'h2,
        ACD_MODE_REDIRECT = 2'h3
    } acd_mode_t;

    // delay adjustment select of one-step timing
    typedef enum logic [1:0]
    {
        ACD_DLY_NONE = 2'h0,
        ACD_DLY_ONE  = 2'h1,
        ACD_DLY_TWO  = 2'h2,
        ACD_DLY_RSVD = 2'h3
    } acd_dly_t;

    // rewrite operation class, one-hot
    typedef enum logic [5:0]
    {
        ACD_RK_NOP    = 6'h01,
        ACD_RK_SWAP   = 6'h02,
        ACD_RK_ONE    = 6'h04,
        ACD_RK_TWO    = 6'h08,
        ACD_RK_ORIGIN = 6'h10,
        ACD_RK_OTHER  = 6'h20
    } acd_rew_kind_t;

endpackage : acd_pkg

// ---- verilog/acd_field_slice.sv ----
// Purpose: cut the fields of one returned action word
// Assumes: word is stable while the lookup result is valid
// Notes:   purely combinational, fixed bit positions
`include "acd_defs.svh"

module acd_field_slice
    import acd_pkg::*;
(
    input  wire logic [`ACD_ACT_W-1:0]     action_word,
    output acd_mode_t                      port_set_mode,
    output logic                           learn_suppress,
    output logic                           acl_police_on,
    output logic [`ACD_POL_SEL_W-1:0]      acl_policer_select,
    output logic                           classifier_policer_exclusive,
    output logic [`ACD_PSET_W-1:0]         egress_port_set,
    output logic [`ACD_REW_W-1:0]          rewrite_command
);

    assign port_set_mode = acd_mode_t'(action_word[`ACD_MODE_LSB +: `ACD_MODE_W]);
    assign learn_suppress = action_word[`ACD_LRN_BIT];
    assign acl_police_on = action_word[`ACD_POL_ON_BIT];
    assign acl_policer_select = action_word[`ACD_POL_SEL_LSB +: `ACD_POL_SEL_W];
    assign classifier_policer_exclusive = action_word[`ACD_EXCL_BIT];
    assign egress_port_set = action_word[`ACD_PSET_LSB +: `ACD_PSET_W];
    assign rewrite_command = action_word[`ACD_REW_LSB +: `ACD_REW_W];

endmodule : acd_field_slice

// ---- tb/acd_action_checker.sv ----
// Purpose: port properties of the action decoder
// Assumes: bound to acd_action_decoder by tb
// Notes:   decode is combinational, so most checks hold in-cycle
`include "acd_defs.svh"
module acd_action_checker
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        result_valid,
    input wire logic [39:0] action_first,
    input wire logic [39:0] action_second,
    input wire logic [10:0] fwd_filter_set,
    input wire logic [10:0] addr_lookup_set,
    input wire logic        out_valid,
    input wire logic        learn_suppress,
    input wire logic        police_on,
    input wire logic [8:0]  policer_select,
    input wire logic        policer_exclusive,
    input wire logic [1:0]  port_set_mode,
    input wire logic [10:0] fwd_dest_set,
    input wire logic [8:0]  rewrite_command,
    input wire logic        rew_mac_swap,
    input wire logic        rew_ptp_one_step,
    input wire logic [1:0]  rew_dly_sel,
    input wire logic        rew_ptp_two_step,
    input wire logic [5:0]  rew_ts_id,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_valid_same: assert property (out_valid == result_valid)
        else $error("valid not passed through");
    a_learn_any: assert property (learn_suppress |-> action_first[8] || action_second[8])
        else $error("learn suppress without cause");
    a_police_first: assert property (police_on |-> action_first[9])
        else $error("police flag not from first lookup");
    a_index_bits: assert property (policer_select == action_first[18:10])
        else $error("policer index misplaced");
    a_excl_second: assert property (policer_exclusive |-> action_second[19])
        else $error("exclusive flag not from second lookup");
    a_mode_max: assert property (port_set_mode != 2'h0 |->
        port_set_mode == ((action_first[6:5] > action_second[6:5]) ? action_first[6:5] : action_second[6:5]))
        else $error("merged mode wrong");
    a_cpu_kept: assert property (fwd_dest_set[10] == (fwd_filter_set[10] & addr_lookup_set[10]))
        else $error("cpu port altered");
    a_cmd_merge: assert property (rewrite_command != 9'h000 |-> rewrite_command ==
        ((action_second[34:31] != 4'h0) ? action_second[39:31] : action_first[39:31]))
        else $error("command merge wrong");
    a_swap_code: assert property (rew_mac_swap == (rewrite_command[3:0] == 4'h8))
        else $error("swap decode wrong");
    a_one_code: assert property (rew_ptp_one_step |-> rewrite_command[2:0] == 3'h2)
        else $error("one-step decode wrong");
    a_dly_sel: assert property (rew_dly_sel == (rew_ptp_one_step ? rewrite_command[4:3] : 2'h0))
        else $error("delay select wrong");
    a_ts_ident: assert property (rew_ts_id == (rew_ptp_two_step ? rewrite_command[8:3] : 6'h00))
        else $error("stamp identifier wrong");
    a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
endmodule : acd_action_checker

// ---- tb/acd_far_sink.sv ----
// Purpose: stand-in for the forwarding stage learning logic
// Assumes: one frame per cycle while out_valid is high
// Notes:   only counts frames it may learn from
module acd_far_sink
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic out_valid,
    input  wire logic learn_suppress,
    output int        learned
);
    timeunit 1ns;
    timeprecision 100ps;
    always_ff @(posedge clk or posedge rst)
        if (rst)
            learned <= 0;
        else if (out_valid && !learn_suppress)
            learned <= learned + 1;
endmodule : acd_far_sink

// ---- tb/tb.sv ----
// Purpose: random frame decode against an integer model
// Assumes: one frame per cycle, register port as in hand-over
// Notes:   entries are built with undefined command bits at zero
`include "acd_defs.svh"
module tb
    import acd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst, result_valid, reg_wr, reg_rd, out_valid, learn_suppress, police_on;
    logic policer_exclusive, rew_none, rew_mac_swap, rew_ptp_one_step, rew_corr_addsub;
    logic rew_add_egress_dly, rew_sub_rx_dly, rew_ptp_two_step, rew_ptp_origin;
    logic [39:0] action_first, action_second;
    logic [3:0]  ingress_port;
    logic [10:0] fwd_filter_set, addr_lookup_set, egress_port_set, fwd_dest_set;
    logic [8:0]  policer_select, rewrite_command;
    logic [1:0]  port_set_mode, rew_dly_sel;
    logic [5:0]  rew_ts_id;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    int num_errors, total_checks, en, bk, frames, lrns, lrnd, lc, lk, cyc, learned;

    acd_action_decoder #(.CPU_PORT(10), .IGR_PORTS(12)) DUT (.*);
    acd_far_sink far_i (.clk(clk), .rst(rst), .out_valid(out_valid),
        .learn_suppress(learn_suppress), .learned(learned));

    task automatic chk(string n, logic [39:0] e, logic [39:0] s);
        total_checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("unexpected %s expected %0h seen %0h", n, e, s);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize

    // undefined bits zero
    // entry builder: undefined bits of each code stay zero
    function automatic logic [8:0] mk_cmd(int k, logic [31:0] r);
        case (k)
            0: mk_cmd = 9'h000;
            1: mk_cmd = 9'h008;
            2: mk_cmd = 9'h009;
            3: mk_cmd = {1'b0, r[7], 1'b0, r[5], r[4:3], 3'h2};
            default: mk_cmd = {r[5:0], 3'h3};
        endcase
    endfunction : mk_cmd

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(logic [7:0] a, logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk("reg_rdata", e, reg_rdata);
    endtask : rd

    task automatic frame();
        logic [39:0] w0, w1;
        logic [10:0] fl, lu, p, d, nn;
        logic [8:0]  c;
        int m1, m2, m, pt, one, two, lr;
        w0 = {mk_cmd($urandom % 5, $urandom), 31'($urandom)};
        w1 = {mk_cmd($urandom % 5, $urandom), 31'($urandom)};
        fl = 11'($urandom);
        lu = 11'($urandom);
        // port numbers above 11 reach the pin too and never count as backplane
        pt = $urandom % 16;
        @(posedge clk);
        result_valid <= 1'b1;
        action_first <= w0;
        action_second <= w1;
        fwd_filter_set <= fl;
        addr_lookup_set <= lu;
        ingress_port <= 4'(pt);
        m1 = w0[6:5];
        m2 = w1[6:5];
        m = en ? ((m1 > m2) ? m1 : m2) : 0;
        p = (m2 == 3 || m1 == 0) ? w1[30:20] : ((m2 == 0) ? w0[30:20] : w0[30:20] & w1[30:20]);
        nn = fl & lu;
        d = (m == 0) ? nn : (m == 1) ? nn & p : (m == 2) ? fl & p : p;
        d[10] = nn[10];
        c = !en ? 9'h0 : ((w1[34:31] != 4'h0) ? w1[39:31] : w0[39:31]);
        one = c[3:0] != 4'h8 && c[3:0] != 4'h9 && c[2:0] == 3'h2;
        two = c[3:0] != 4'h8 && c[3:0] != 4'h9 && c[2:0] == 3'h3;
        lr = en && (w0[8] || w1[8]);
        lc = c;
        lk = (c[3:0] == 0) ? 1 : (c[3:0] == 8) ? 2 : (c[3:0] == 9) ? 'h10 : one ? 4 : two ? 8 : 'h20;
        frames++;
        lrns += lr;
        lrnd += !lr;
        @(negedge clk);
        chk("out_valid", 1, out_valid);
        chk("learn", lr, learn_suppress);
        chk("police", en && w0[9], police_on);
        chk("select", w0[18:10], policer_select);
        chk("excl", en && w1[19], policer_exclusive);
        chk("mode", m, port_set_mode);
        if (en)
            chk("pset", p, egress_port_set);
        chk("dest", d, fwd_dest_set);
        chk("cmd", c, rewrite_command);
        chk("none", c[3:0] == 0, rew_none);
        chk("swap", c[3:0] == 8, rew_mac_swap);
        chk("one", one, rew_ptp_one_step);
        chk("addsub", one && c[7], rew_corr_addsub);
        chk("egr_dly", one && c[5], rew_add_egress_dly);
        chk("rx_dly", one && c[5] && !bk[pt], rew_sub_rx_dly);
        chk("dly_sel", one ? c[4:3] : 0, rew_dly_sel);
        chk("two", two, rew_ptp_two_step);
        chk("ts_id", two ? c[8:3] : 0, rew_ts_id);
        chk("origin", c[3:0] == 9, rew_ptp_origin);
    endtask : frame

    task automatic idle();
        @(posedge clk);
        result_valid <= 1'b0;
    endtask : idle

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            num_errors++;
            summarize();
        end
    end

    initial
    begin
        {rst, result_valid, reg_wr, reg_rd} = 4'h8;
        {action_first, action_second, ingress_port, fwd_filter_set, addr_lookup_set} = '0;
        {reg_addr, reg_wdata} = '0;
        en = 1;
        void'($urandom(23709));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(8'h00, 32'h1);
        rd(8'h04, 32'h0);
        rd(8'h0C, 32'h0);
        rd(8'h10, 32'h0);
        bk = $urandom & 'hFFF;
        wr(8'h04, bk);
        rd(8'h04, bk);
        repeat (400) frame();
        idle();
        rd(8'h08, {7'h0, 6'(lk), 10'h0, 9'(lc)});
        rd(8'h0C, {16'(lrns), 16'(frames)});
        wr(8'h00, 32'h0);
        en = 0;
        repeat (20) frame();
        idle();
        wr(8'h00, 32'h1);
        en = 1;
        wr(8'h0C, 32'h0);
        {frames, lrns} = '0;
        repeat (20) frame();
        idle();
        rd(8'h0C, {16'(lrns), 16'(frames)});
        chk("learned", lrnd, learned);
        summarize();
    end
endmodule : tb

bind acd_action_decoder acd_action_checker chk_i (.*);
